// ===== rtl/acc_pkg.sv
package acc_pkg;

    // ****************************************
    // Register addresses on the special-function port
    // ****************************************
    localparam logic [7:0] ADDR_P3SEL  = 8'hba;
    localparam logic [7:0] ADDR_HVA    = 8'hd6;
    localparam logic [7:0] ADDR_CFG    = 8'hbc;
    localparam logic [7:0] ADDR_CTL    = 8'he8;
    localparam logic [7:0] ADDR_RES_HI = 8'hbf;
    localparam logic [7:0] ADDR_RES_LO = 8'hbe;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] P3SEL_RST = 8'h00;
    localparam logic [7:0] HVA_RST   = 8'h00;
    localparam logic [7:0] CFG_RST   = 8'hf8;
    localparam logic [7:0] CTL_RST   = 8'h00;
    localparam logic [7:0] RES_RST   = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTL_EN_BIT   = 7;
    localparam int CTL_TM_BIT   = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_CM_LSB   = 2;
    localparam int CTL_LJ_BIT   = 0;
    localparam int HVA_EN_BIT   = 7;
    localparam int CFG_DIV_LSB  = 3;

    // ****************************************
    // Sizes and counts
    // ****************************************
    localparam int          RES_W        = 10;
    localparam int          DIV_W        = 5;
    localparam logic [1:0]  TRACK_CLOCKS = 2'h3;
    localparam logic [9:0]  SAR_MSB_MASK = 10'h200;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        start_sw   = 2'h0,
        start_t3   = 2'h1,
        start_ext  = 2'h2,
        start_t2   = 2'h3
    } acc_start_e;

    typedef enum logic [2:0] {
        st_idle  = 3'h1,
        st_track = 3'h2,
        st_conv  = 3'h4
    } acc_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } acc_sfr_req_s;

endpackage

// ===== rtl/acc_clk_div.sv
module acc_clk_div (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    // Control
    input  wire logic                     clr_i,
    input  wire logic                     run_i,
    input  wire logic [acc_pkg::DIV_W-1:0] div_i,
    // Conversion clock tick
    output logic                          tick_o
);

    logic [acc_pkg::DIV_W-1:0] cnt;

    // One tick every div_i plus one system clocks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (clr_i || !run_i) begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end else if (cnt == div_i) begin
            cnt    <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 5'h1;
            tick_o <= 1'b0;
        end
    end

endmodule

// ===== rtl/acc_sar_reg.sv
module acc_sar_reg (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_b_i,
    // Sequencing
    input  wire logic                     load_i,
    input  wire logic                     step_i,
    input  wire logic                     cmp_i,
    // Trial word and result
    output logic [acc_pkg::RES_W-1:0]     trial_o,
    output logic [acc_pkg::RES_W-1:0]     result_o,
    output logic                          done_o
);

    logic [acc_pkg::RES_W-1:0] mask;
    logic [acc_pkg::RES_W-1:0] kept;

    // Drop the trial bit when the comparator says input is below it
    assign kept = cmp_i ? trial_o : (trial_o & ~mask);

    // Binary search, most significant bit first
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mask     <= '0;
            trial_o  <= '0;
            result_o <= '0;
            done_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                mask    <= acc_pkg::SAR_MSB_MASK;
                trial_o <= acc_pkg::SAR_MSB_MASK;
            end else if (step_i && (mask != '0)) begin
                if (mask[0]) begin
                    result_o <= kept;
                    trial_o  <= kept;
                    done_o   <= 1'b1;
                    mask     <= '0;
                end else begin
                    trial_o <= kept | (mask >> 1);
                    mask    <= mask >> 1;
                end
            end
        end
    end

endmodule

// ===== rtl/acc_top.sv
module acc_top (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    // Register port
    input  wire acc_pkg::acc_sfr_req_s sfr_i,
    output logic [7:0]                 sfr_rdata_o,
    // Trigger inputs
    input  wire logic                  timer3_ovf_i,
    input  wire logic                  timer2_ovf_i,
    input  wire logic                  external_convert_start_i,
    // System state
    input  wire logic                  standby_i,
    input  wire logic                  diff_mode_i,
    // Analog core
    input  wire logic                  sar_cmp_i,
    output logic [acc_pkg::RES_W-1:0]  sar_trial_o,
    output logic                       track_o,
    output logic                       converter_enable_o,
    // Input selection and amplifier
    output logic [7:0]                 port3_analog_pin_select_o,
    output logic                       hv_amp_enable_o,
    output logic [3:0]                 hv_amp_gain_code_o,
    output logic                       hv_ref_to_neg_o,
    // Status
    output logic                       conversion_busy_o,
    output logic                       conversion_done_o
);

    // ****************************************
    // Declarations
    // ****************************************
    logic                       wr_p3;
    logic                       wr_hva;
    logic                       wr_cfg;
    logic                       wr_ctl;
    logic                       track_mode;
    logic [1:0]                 start_src;
    logic [1:0]                 eff_src;
    logic                       left_justify;
    logic [acc_pkg::DIV_W-1:0]  clk_period;
    logic [2:0]                 pga_gain;
    logic [7:0]                 result_high_byte;
    logic [7:0]                 result_low_byte;
    logic                       ext_prev;
    logic                       ext_rise;
    logic                       sw_start;
    logic                       trig;
    logic                       start_evt;
    logic                       tick;
    logic                       sar_load;
    logic                       sar_done;
    logic [acc_pkg::RES_W-1:0]  sar_result;
    logic [1:0]                 track_cnt;
    logic                       next_track;
    logic [7:0]                 next_rdata;
    acc_pkg::acc_state_e        state;
    acc_pkg::acc_state_e        next_state;

    // ****************************************
    // Register writes
    // ****************************************

    // Address decode of writes
    assign wr_p3  = sfr_i.wr && (sfr_i.addr == acc_pkg::ADDR_P3SEL);
    assign wr_hva = sfr_i.wr && (sfr_i.addr == acc_pkg::ADDR_HVA);
    assign wr_cfg = sfr_i.wr && (sfr_i.addr == acc_pkg::ADDR_CFG);
    assign wr_ctl = sfr_i.wr && (sfr_i.addr == acc_pkg::ADDR_CTL);

    // Port-3 pin select, all eight bits free
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port3_analog_pin_select_o <= acc_pkg::P3SEL_RST;
        end else if (wr_p3) begin
            port3_analog_pin_select_o <= sfr_i.wdata;
        end
    end

    // Amplifier enable and gain code
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hv_amp_enable_o    <= acc_pkg::HVA_RST[acc_pkg::HVA_EN_BIT];
            hv_amp_gain_code_o <= acc_pkg::HVA_RST[3:0];
        end else if (wr_hva) begin
            hv_amp_enable_o    <= sfr_i.wdata[acc_pkg::HVA_EN_BIT];
            hv_amp_gain_code_o <= sfr_i.wdata[3:0];
        end
    end

    // Reference goes to the negative input only for differential reads
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hv_ref_to_neg_o <= 1'b0;
        end else begin
            hv_ref_to_neg_o <= hv_amp_enable_o && diff_mode_i;
        end
    end

    // Clock period and internal amplifier gain
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_period <= acc_pkg::CFG_RST[7:acc_pkg::CFG_DIV_LSB];
            pga_gain   <= acc_pkg::CFG_RST[2:0];
        end else if (wr_cfg) begin
            clk_period <= sfr_i.wdata[7:acc_pkg::CFG_DIV_LSB];
            pga_gain   <= sfr_i.wdata[2:0];
        end
    end

    // Control fields held by software
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            converter_enable_o <= acc_pkg::CTL_RST[acc_pkg::CTL_EN_BIT];
            track_mode         <= acc_pkg::CTL_RST[acc_pkg::CTL_TM_BIT];
            start_src          <= acc_pkg::CTL_RST[acc_pkg::CTL_CM_LSB+:2];
            left_justify       <= acc_pkg::CTL_RST[acc_pkg::CTL_LJ_BIT];
        end else if (wr_ctl) begin
            converter_enable_o <= sfr_i.wdata[acc_pkg::CTL_EN_BIT];
            track_mode         <= sfr_i.wdata[acc_pkg::CTL_TM_BIT];
            start_src          <= sfr_i.wdata[acc_pkg::CTL_CM_LSB+:2];
            left_justify       <= sfr_i.wdata[acc_pkg::CTL_LJ_BIT];
        end
    end

    // Done flag: a completion beats a clearing write in the same cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conversion_done_o <= acc_pkg::CTL_RST[acc_pkg::CTL_DONE_BIT];
        end else if (sar_done && state == acc_pkg::st_conv) begin
            conversion_done_o <= 1'b1;
        end else if (wr_ctl && !sfr_i.wdata[acc_pkg::CTL_DONE_BIT]) begin
            conversion_done_o <= 1'b0;
        end
    end

    // ****************************************
    // Start of conversion
    // ****************************************

    // Previous level of the external start input; idle high so reset makes no false edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_prev <= 1'b1;
        end else begin
            ext_prev <= external_convert_start_i;
        end
    end

    assign ext_rise = external_convert_start_i && !ext_prev;
    // Source code written together with the busy bit decides
    assign sw_start = wr_ctl && sfr_i.wdata[acc_pkg::CTL_BUSY_BIT]
                      && (sfr_i.wdata[acc_pkg::CTL_CM_LSB+:2] == acc_pkg::start_sw);
    // A control write brings its own source code into force at once
    assign eff_src = wr_ctl ? sfr_i.wdata[acc_pkg::CTL_CM_LSB+:2] : start_src;

    // Exactly one source counts at a time
    always_comb begin
        unique case (acc_pkg::acc_start_e'(eff_src))
            acc_pkg::start_sw:  trig = sw_start;
            acc_pkg::start_t3:  trig = timer3_ovf_i;
            acc_pkg::start_ext: trig = ext_rise;
            acc_pkg::start_t2:  trig = timer2_ovf_i;
        endcase
    end

    assign start_evt = trig && converter_enable_o && (state == acc_pkg::st_idle);

    // ****************************************
    // Conversion clock and successive approximation
    // ****************************************

    // Divider restarts at the start event so periods align to it
    acc_clk_div u_div (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .clr_i   (start_evt),
        .run_i   (converter_enable_o),
        .div_i   (clk_period),
        .tick_o  (tick)
    );

    assign sar_load = (next_state == acc_pkg::st_conv) && (state != acc_pkg::st_conv);

    acc_sar_reg u_sar (
        .clk_i    (clk_i),
        .rst_b_i  (rst_b_i),
        .load_i   (sar_load),
        .step_i   (tick && state == acc_pkg::st_conv),
        .cmp_i    (sar_cmp_i),
        .trial_o  (sar_trial_o),
        .result_o (sar_result),
        .done_o   (sar_done)
    );

    // ****************************************
    // Sequencer
    // ****************************************

    // Next state of the track and convert sequence
    always_comb begin
        next_state = state;
        unique case (state)
            acc_pkg::st_idle: begin
                if (start_evt) begin
                    if (track_mode && eff_src != acc_pkg::start_ext) begin
                        next_state = acc_pkg::st_track;
                    end else begin
                        next_state = acc_pkg::st_conv;
                    end
                end
            end
            acc_pkg::st_track: begin
                if (tick && track_cnt == acc_pkg::TRACK_CLOCKS - 2'h1) begin
                    next_state = acc_pkg::st_conv;
                end
            end
            acc_pkg::st_conv: begin
                if (sar_done) begin
                    next_state = acc_pkg::st_idle;
                end
            end
            default: next_state = acc_pkg::st_idle;
        endcase
        if (!converter_enable_o) begin
            next_state = acc_pkg::st_idle;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= acc_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Busy spans tracking and conversion
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conversion_busy_o <= 1'b0;
        end else begin
            conversion_busy_o <= (next_state != acc_pkg::st_idle);
        end
    end

    // Counts conversion clocks spent tracking
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            track_cnt <= 2'h0;
        end else if (state != acc_pkg::st_track) begin
            track_cnt <= 2'h0;
        end else if (tick) begin
            track_cnt <= track_cnt + 2'h1;
        end
    end

    // Track switch drive
    always_comb begin
        if (!converter_enable_o || standby_i) begin
            next_track = 1'b0;
        end else if (!track_mode) begin
            next_track = (state == acc_pkg::st_idle);
        end else if (start_src == acc_pkg::start_ext) begin
            next_track = (state == acc_pkg::st_idle) && !external_convert_start_i;
        end else begin
            next_track = (state == acc_pkg::st_track);
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            track_o <= 1'b0;
        end else begin
            track_o <= next_track;
        end
    end

    // ****************************************
    // Result bytes
    // ****************************************

    // Justify on completion; right form sign-extends differential reads
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_high_byte <= acc_pkg::RES_RST;
            result_low_byte  <= acc_pkg::RES_RST;
        end else if (sar_done && state == acc_pkg::st_conv) begin
            if (left_justify) begin
                result_high_byte <= sar_result[9:2];
                result_low_byte  <= {sar_result[1:0], 6'h00};
            end else begin
                result_high_byte <= {{6{diff_mode_i & sar_result[9]}}, sar_result[9:8]};
                result_low_byte  <= sar_result[7:0];
            end
        end
    end

    // ****************************************
    // Register reads
    // ****************************************

    // Read mux; unmapped addresses answer zero
    always_comb begin
        unique case (sfr_i.addr)
            acc_pkg::ADDR_P3SEL:  next_rdata = port3_analog_pin_select_o;
            acc_pkg::ADDR_HVA:    next_rdata = {hv_amp_enable_o, 3'h0, hv_amp_gain_code_o};
            acc_pkg::ADDR_CFG:    next_rdata = {clk_period, pga_gain};
            acc_pkg::ADDR_CTL:    next_rdata = {converter_enable_o, track_mode,
                                                conversion_done_o, conversion_busy_o,
                                                start_src, 1'b0, left_justify};
            acc_pkg::ADDR_RES_HI: next_rdata = result_high_byte;
            acc_pkg::ADDR_RES_LO: next_rdata = result_low_byte;
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_i.rd) begin
            sfr_rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    p3sel_write_a: assert property (wr_p3 |=> port3_analog_pin_select_o == $past(sfr_i.wdata))
        else $error("port-3 select not stored");
    any_mix_a: assert property (wr_p3 && sfr_i.wdata[7] && sfr_i.wdata[0]
                                |=> port3_analog_pin_select_o[7] && port3_analog_pin_select_o[0])
        else $error("port-3 select mix refused");
    hva_enable_a: assert property (wr_hva |=> hv_amp_enable_o == $past(sfr_i.wdata[7]))
        else $error("amplifier enable wrong");
    gain_code_a: assert property (wr_hva |=> hv_amp_gain_code_o == $past(sfr_i.wdata[3:0]))
        else $error("gain code wrong");
    hva_read_a: assert property (sfr_i.rd && sfr_i.addr == acc_pkg::ADDR_HVA
                                 |=> sfr_rdata_o[6:4] == 3'h0)
        else $error("amplifier reserved bits not zero");
    hv_ref_a: assert property (hv_amp_enable_o && diff_mode_i |=> hv_ref_to_neg_o)
        else $error("reference not on negative input");
    sw_start_a: assert property (start_evt && sw_start |=> conversion_busy_o)
        else $error("busy write did not start");
    src_gate_a: assert property (state == acc_pkg::st_idle && start_src != acc_pkg::start_sw
                                 && !timer3_ovf_i && !timer2_ovf_i && !ext_rise && !sw_start
                                 |=> !conversion_busy_o)
        else $error("conversion from wrong source");
    done_set_a: assert property (sar_done && state == acc_pkg::st_conv
                                 |=> !conversion_busy_o && conversion_done_o)
        else $error("completion not flagged");
    disabled_a: assert property (!converter_enable_o |=> !conversion_busy_o
                                 ##1 (!conversion_busy_o || $past(converter_enable_o)))
        else $error("converting while disabled");
    track_three_a: assert property (state == acc_pkg::st_track && tick && track_cnt == 2'h2
                                    |=> state == acc_pkg::st_conv)
        else $error("tracking length not three");
    cont_track_a: assert property (converter_enable_o && !standby_i && !track_mode
                                   && state == acc_pkg::st_idle |=> track_o)
        else $error("continuous tracking missing");
    standby_a: assert property (standby_i |=> !track_o)
        else $error("tracking during standby");
    ext_lp_a: assert property (start_evt && track_mode && eff_src == acc_pkg::start_ext
                               |=> state == acc_pkg::st_conv)
        else $error("external edge did not convert");
    left_just_a: assert property (sar_done && state == acc_pkg::st_conv && left_justify
                                  |=> result_low_byte[5:0] == 6'h00
                                      && result_high_byte == $past(sar_result[9:2]))
        else $error("left justify wrong");

    sw_conv_c: cover property (sw_start && start_evt ##[1:400] sar_done);
    lp_track_c: cover property (state == acc_pkg::st_track ##[1:200] state == acc_pkg::st_conv);
    ext_conv_c: cover property (ext_rise && start_evt ##[1:400] conversion_done_o);
    clear_race_c: cover property (sar_done && wr_ctl && state == acc_pkg::st_conv);

endmodule

// ===== tb/acc_trig_model.sv
module acc_trig_model (
    // Clock and command
    input  wire logic       clk_i,
    input  wire logic       go_i,
    input  wire logic [1:0] src_i,
    // Trigger lines
    output logic            t3_o,
    output logic            t2_o,
    output logic            ext_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Timer overflows pulse once; external line dips low to set tracking length
    initial begin
        {t3_o, t2_o, ext_o} = 3'h1;
        forever begin
            @(posedge clk_i);
            t3_o <= go_i && src_i == 2'h1;
            t2_o <= go_i && src_i == 2'h3;
            if (go_i && src_i == 2'h2) begin
                ext_o <= 1'b0;
                repeat (4) @(posedge clk_i);
                ext_o <= 1'b1;
            end
        end
    end
endmodule

// ===== tb/acc_top_tb.sv
module acc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk_i, rst_b_i, go, standby, diff;
    logic                  t3, t2, ext, busy, done, trk, hv_en, ref_neg, en;
    logic [1:0]            src;
    logic [3:0]            gain;
    logic [7:0]            rdata, p3;
    logic [9:0]            vin, trial, q[$];
    logic                  rd_d;
    logic [31:0]           seed;
    int                    bad_count, checks_done;
    acc_pkg::acc_sfr_req_s sfr;

    acc_top u_acc_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .timer3_ovf_i(t3), .timer2_ovf_i(t2), .external_convert_start_i(ext),
        .standby_i(standby), .diff_mode_i(diff), .sar_cmp_i(vin >= trial),
        .sar_trial_o(trial), .track_o(trk), .converter_enable_o(en),
        .port3_analog_pin_select_o(p3), .hv_amp_enable_o(hv_en), .hv_amp_gain_code_o(gain),
        .hv_ref_to_neg_o(ref_neg), .conversion_busy_o(busy), .conversion_done_o(done));
    acc_trig_model u_acc_trig_model (.clk_i(clk_i), .go_i(go), .src_i(src),
        .t3_o(t3), .t2_o(t2), .ext_o(ext));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_i);
        sfr.wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr <= '{a, 1'b0, 1'b1, 8'h00};
        q.push_back({2'h0, e});
        @(posedge clk_i);
        sfr.rd <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_done;
        int n;
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (done !== 1'b1) begin
            bad_count++;
            final_report;
        end
    endtask

    // Clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Read data is compared with the oldest noted value
    always @(posedge clk_i) rd_d <= sfr.rd;
    always @(negedge clk_i) if (rd_d === 1'b1) check({2'h0, rdata}, q.pop_front());

    // Main sequence
    initial begin
        sfr = '0;
        {go, src, vin, standby, diff, rst_b_i} = '0;
        seed = 32'h2cf677f6;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(acc_pkg::ADDR_P3SEL, 8'h00);
        rd(acc_pkg::ADDR_CFG, 8'hf8);
        rd(8'h55, 8'h00);
        wr(acc_pkg::ADDR_P3SEL, 8'ha5);
        check({2'h0, p3}, 10'h0a5);
        wr(acc_pkg::ADDR_HVA, 8'hff);
        rd(acc_pkg::ADDR_HVA, 8'h8f);
        check({hv_en, gain}, 10'h01f);
        wr(acc_pkg::ADDR_CTL, 8'h10);
        check(busy, 1'b0);
        wr(acc_pkg::ADDR_CFG, 8'h00);
        for (int k = 0; k < 8; k++) begin
            seed = lfsr(seed);
            vin <= seed[9:0];
            wr(acc_pkg::ADDR_CTL, {1'b1, k[2], 2'h0, k[1:0], 1'b0, k[0]});
            wr(acc_pkg::ADDR_CTL, {1'b1, k[2], 2'h1, k[1:0], 1'b0, k[0]});
            check({busy, done}, {k[1:0] == 2'h0, 1'b0});
            src <= k[1:0];
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            wait_done;
            check(busy, 1'b0);
            rd(acc_pkg::ADDR_RES_HI, k[0] ? vin[9:2] : {6'h0, vin[9:8]});
            rd(acc_pkg::ADDR_RES_LO, k[0] ? {vin[1:0], 6'h0} : vin[7:0]);
            check(trk, !k[2]);
        end
        check(en, 1'b1);
        rd(acc_pkg::ADDR_CTL, 8'hed);
        standby <= 1'b1;
        diff <= 1'b1;
        wr(acc_pkg::ADDR_HVA, 8'h80);
        @(posedge clk_i);
        check(trk, 1'b0);
        check(ref_neg, 1'b1);
        // Differential right-justified reading sign-extends the high byte
        vin <= 10'h3c5;
        wr(acc_pkg::ADDR_CTL, 8'h80);
        wr(acc_pkg::ADDR_CTL, 8'h90);
        wait_done;
        rd(acc_pkg::ADDR_RES_HI, 8'hff);
        rd(acc_pkg::ADDR_RES_LO, 8'hc5);
        final_report;
    end
endmodule
